// >>> verilog/fwsr_regs.vh
`ifndef FWSR_REGS_VH
`define FWSR_REGS_VH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define FWSR_OFF_CTRL 12'h000
`define FWSR_OFF_ADDR 12'h004
`define FWSR_OFF_WDATA 12'h008
`define FWSR_OFF_STATUS 12'h00C
`define FWSR_OFF_RDATA 12'h010
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define FWSR_CTRL_OP_LSB 0
`define FWSR_CTRL_OP_MSB 1
`define FWSR_CTRL_FRAME_CE 4
`define FWSR_OP_NONE 2'h0
`define FWSR_OP_WRITE 2'h1
`define FWSR_OP_READ 2'h2
`define FWSR_OP_POLL 2'h3
// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define FWSR_ST_BUSY 0
`define FWSR_ST_DONE 1
`define FWSR_ST_FAIL 2
`define FWSR_ST_TOGGLE 3
`define FWSR_ST_TIMER 4
`define FWSR_ST_RDY_PIN 5
`define FWSR_ST_LIMIT 6
// ----------------------------------------------------------------
// flash data bit positions and commands
// ----------------------------------------------------------------
`define FWSR_BIT_TOGGLE_ONE 6
`define FWSR_BIT_TIMING_LIMIT 5
`define FWSR_BIT_ERASE_TIMER 3
`define FWSR_RESET_CMD 16'h00F0
// ----------------------------------------------------------------
// timing, ns figures and derived counts at 40 MHz
// ----------------------------------------------------------------
`define FWSR_CLK_NS 25
`define FWSR_T_ACCESS_NS 90
`define FWSR_T_WE_PULSE_NS 35
`define FWSR_T_RECOVER_NS 20
`define FWSR_ACC_CYC ((`FWSR_T_ACCESS_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_WE_CYC ((`FWSR_T_WE_PULSE_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_REC_CYC ((`FWSR_T_RECOVER_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`endif

// >>> verilog/fwsr_host.v
// Implementation choices: the APB slave port and the placing of the registers.
`include "fwsr_regs.vh"
module fwsr_host #(
  parameter AW = 20,
  parameter DW = 16
) (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // flash pins
  output reg [AW-1:0] flash_addr,
  output reg [DW-1:0] flash_dq_out,
  output reg flash_dq_oe,
  input wire [DW-1:0] flash_dq_in,
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  input wire ready_busy_in
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RD = 5'h02;
  localparam [4:0] S_WR = 5'h04;
  localparam [4:0] S_GAP = 5'h08;
  localparam [4:0] S_EVAL = 5'h10;
  localparam integer ACC_CYC_I = `FWSR_ACC_CYC;
  localparam integer WE_CYC_I = `FWSR_WE_CYC;
  localparam integer REC_CYC_I = `FWSR_REC_CYC;
  // counts are cut to the width of the 4-bit cycle counter
  localparam [3:0] ACC_CYC = ACC_CYC_I[3:0];
  localparam [3:0] WE_CYC = WE_CYC_I[3:0];
  localparam [3:0] REC_CYC = REC_CYC_I[3:0];

  reg [4:0] state;
  reg [3:0] cnt;
  reg [1:0] op;
  reg frame_ce;
  reg [AW-1:0] addr_reg;
  reg [DW-1:0] wdata_reg;
  reg [DW-1:0] rdata_reg;
  reg busy, done, fail, toggle_seen, timer_flag, limit_seen, rdy_pin;
  reg have_prev, prev_bit, recheck;
  wire acc = psel && penable && pready;
  wire wr_ctrl = acc && pwrite && (paddr == `FWSR_OFF_CTRL);
  wire [1:0] wr_op = pwdata[`FWSR_CTRL_OP_MSB:`FWSR_CTRL_OP_LSB];
  wire new_bit = rdata_reg[`FWSR_BIT_TOGGLE_ONE];

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      addr_reg <= {AW{1'b0}};
      wdata_reg <= {DW{1'b0}};
      frame_ce <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        if (paddr == `FWSR_OFF_CTRL) begin
          prdata[`FWSR_CTRL_OP_MSB:`FWSR_CTRL_OP_LSB] <= op;
          prdata[`FWSR_CTRL_FRAME_CE] <= frame_ce;
        end else if (paddr == `FWSR_OFF_ADDR) begin
          prdata[AW-1:0] <= addr_reg;
        end else if (paddr == `FWSR_OFF_WDATA) begin
          prdata[DW-1:0] <= wdata_reg;
        end else if (paddr == `FWSR_OFF_STATUS) begin
          prdata[`FWSR_ST_BUSY] <= busy;
          prdata[`FWSR_ST_DONE] <= done;
          prdata[`FWSR_ST_FAIL] <= fail;
          prdata[`FWSR_ST_TOGGLE] <= toggle_seen;
          prdata[`FWSR_ST_TIMER] <= timer_flag;
          prdata[`FWSR_ST_RDY_PIN] <= rdy_pin;
          prdata[`FWSR_ST_LIMIT] <= limit_seen;
        end else if (paddr == `FWSR_OFF_RDATA) begin
          prdata[DW-1:0] <= rdata_reg;
        end else begin
          pslverr <= 1'b1;
        end
      end
      // config registers hold still while an operation runs
      if (acc && pwrite && !busy) begin
        if (paddr == `FWSR_OFF_CTRL) begin
          frame_ce <= pwdata[`FWSR_CTRL_FRAME_CE];
        end else if (paddr == `FWSR_OFF_ADDR) begin
          addr_reg <= pwdata[AW-1:0];
        end else if (paddr == `FWSR_OFF_WDATA) begin
          wdata_reg <= pwdata[DW-1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // flash cycle engine and toggle polling
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      cnt <= 4'h0;
      op <= `FWSR_OP_NONE;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      toggle_seen <= 1'b0;
      timer_flag <= 1'b0;
      limit_seen <= 1'b0;
      rdy_pin <= 1'b1;
      have_prev <= 1'b0;
      prev_bit <= 1'b0;
      recheck <= 1'b0;
      rdata_reg <= {DW{1'b0}};
      flash_addr <= {AW{1'b0}};
      flash_dq_out <= {DW{1'b0}};
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      rdy_pin <= ready_busy_in;
      case (state)
        S_IDLE: begin
          if (wr_ctrl && !busy && wr_op != `FWSR_OP_NONE) begin
            op <= wr_op;
            busy <= 1'b1;
            done <= 1'b0;
            fail <= 1'b0;
            toggle_seen <= 1'b0;
            limit_seen <= 1'b0;
            // a new poll always starts with a fresh double read
            have_prev <= 1'b0;
            recheck <= 1'b0;
            flash_addr <= addr_reg;
            flash_ce_n <= 1'b0;
            cnt <= 4'h0;
            if (wr_op == `FWSR_OP_WRITE) begin
              flash_dq_out <= wdata_reg;
              flash_dq_oe <= 1'b1;
              flash_we_n <= 1'b0;
              state <= S_WR;
            end else begin
              flash_oe_n <= 1'b0;
              state <= S_RD;
            end
          end
        end
        S_RD: begin
          if (cnt == ACC_CYC - 4'h1) begin
            rdata_reg <= flash_dq_in;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt <= 4'h0;
            state <= S_EVAL;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        S_WR: begin
          if (cnt == WE_CYC - 4'h1) begin
            flash_we_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt <= 4'h0;
            state <= S_GAP;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        S_GAP: begin
          flash_dq_oe <= 1'b0;
          if (cnt == REC_CYC - 4'h1) begin
            cnt <= 4'h0;
            busy <= 1'b0;
            done <= 1'b1;
            state <= S_IDLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        S_EVAL: begin
          timer_flag <= rdata_reg[`FWSR_BIT_ERASE_TIMER];
          // output enable rises unless the next poll read keeps it low
          flash_oe_n <= 1'b1;
          state <= S_IDLE;
          if (op != `FWSR_OP_POLL) begin
            busy <= 1'b0;
            done <= 1'b1;
          end else if (!have_prev) begin
            have_prev <= 1'b1;
            prev_bit <= new_bit;
            state <= S_RD;
          end else if (new_bit == prev_bit) begin
            busy <= 1'b0;
            done <= 1'b1;
          end else if (recheck) begin
            // still toggling after the limit flag: abort with reset command
            fail <= 1'b1;
            toggle_seen <= 1'b1;
            flash_addr <= addr_reg;
            flash_dq_out <= `FWSR_RESET_CMD;
            flash_dq_oe <= 1'b1;
            flash_ce_n <= 1'b0;
            flash_we_n <= 1'b0;
            state <= S_WR;
          end else begin
            toggle_seen <= 1'b1;
            prev_bit <= new_bit;
            if (rdata_reg[`FWSR_BIT_TIMING_LIMIT]) begin
              recheck <= 1'b1;
              limit_seen <= 1'b1;
            end
            state <= S_RD;
          end
          // next poll read: re-frame with chip select and output enable both driven low
          if (op == `FWSR_OP_POLL && state == S_EVAL && !(have_prev && new_bit == prev_bit)
              && !(have_prev && recheck)) begin
            flash_ce_n <= 1'b0;
            flash_oe_n <= 1'b0;
            cnt <= 4'h0;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
      // in chip-select framing, output enable stays low between poll reads
      if (state == S_RD && cnt == ACC_CYC - 4'h1 && op == `FWSR_OP_POLL && frame_ce) begin
        flash_oe_n <= 1'b0;
      end
      if (state == S_IDLE && !busy) begin
        flash_oe_n <= (wr_ctrl && wr_op != `FWSR_OP_NONE && wr_op != `FWSR_OP_WRITE) ? 1'b0 : 1'b1;
      end
    end
  end
endmodule // fwsr_host

// >>> tb/fwsr_flash_model.sv
// flash device seen by the host: toggle status while busy, array data otherwise
module fwsr_flash_model (
  // flash pins
  input wire [19:0] flash_addr,
  input wire [15:0] flash_dq_out,
  input wire flash_dq_oe,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  output logic [15:0] flash_dq_in,
  output logic rb_low,
  // scenario control
  input wire go,
  input wire [7:0] n_busy,
  input wire fail,
  input wire etimer
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] busy = 8'h00;
  logic tog = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [19:0] wa = 20'h00000;
  logic [15:0] wd = 16'h0000;
  wire rd = !flash_ce_n && !flash_oe_n;
  // second toggle bit only moves while an erase is in progress
  wire [15:0] stat = {8'h00, 1'b0, tog, fail, 1'b0, etimer, etimer & tog, 2'h0};
  // open-drain pull low while busy
  always @* rb_low = (busy != 8'h00);
  // released bus shows inverse of last value
  always @* flash_dq_in = rd ? ((busy != 8'h00) ? stat : flash_addr[15:0]) : ~last;
  always @* if (rd) last = flash_dq_in;
  always @(posedge go) busy = n_busy;
  // read ends when either strobe rises
  always @(negedge rd) begin
    if (busy != 8'h00) tog = ~tog;
    if (busy != 8'h00 && !fail) busy = busy - 8'h01;
  end
  // data latched at write strobe rise; reset command ends the algorithm unless the erase timer bit is set
  always @(posedge flash_we_n) if (flash_dq_oe) begin
    wa = flash_addr;
    wd = flash_dq_out;
    if (flash_dq_out == 16'h00F0 && !etimer) busy = 8'h00;
  end
endmodule // fwsr_flash_model

// >>> tb/fwsr_host_properties.sv
// protocol checks on the host's ports
module fwsr_host_props #(
  parameter AW = 20,
  parameter DW = 16
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // flash
  input wire [AW-1:0] flash_addr,
  input wire [DW-1:0] flash_dq_out,
  input wire flash_dq_oe,
  input wire [DW-1:0] flash_dq_in,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  input wire ready_busy_in
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_we;
    !flash_we_n [*2] ##1 flash_we_n;
  endsequence
  sequence s_rd;
    (!flash_ce_n && !flash_oe_n) [*4];
  endsequence
  property p_zero_wait;
    psel && !penable |=> pready;
  endproperty
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  property p_unmapped;
    pready && paddr > 12'h010 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_we_pulse;
    $fell(flash_we_n) |-> s_we;
  endproperty
  property p_dq_drive;
    !flash_we_n |-> flash_dq_oe && !flash_ce_n;
  endproperty
  property p_no_clash;
    !flash_oe_n |-> !flash_dq_oe;
  endproperty
  property p_read_frame;
    ($fell(flash_ce_n) && flash_we_n) || $fell(flash_oe_n) |-> s_rd;
  endproperty
  property p_addr_hold;
    !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr);
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("pready missing");
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe width");
  a_dq_drive: assert property (p_dq_drive) else $error("data not driven");
  a_no_clash: assert property (p_no_clash) else $error("bus contention");
  a_read_frame: assert property (p_read_frame) else $error("read frame width");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
endmodule // fwsr_host_props

// >>> tb/fwsr_host_tb_top.sv
`include "fwsr_regs.vh"
// top level bench: apb driver, read monitor, flash model
module fwsr_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rnd = 32'h7E73C137, q, a;
  wire [31:0] prdata;
  wire pready, pslverr, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, rb_low;
  wire [19:0] flash_addr;
  wire [15:0] flash_dq_out, flash_dq_in;
  logic go = 0, fail = 0, etimer = 0;
  logic [7:0] n_busy = 0;
  int err_count = 0, checked = 0, cyc = 0;
  logic [32:0] exp_q[$], msk_q[$], e, m;
  wire ready_busy_in = rb_low ? 1'b0 : 1'b1; // pull-up
  fwsr_host uut (.*);
  fwsr_flash_model model (.*);
  initial forever #12.5 pclk = ~pclk;
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task check(input string n, input logic [32:0] s, input logic [32:0] x);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task results;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one apb transfer; a read notes its expectation
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
           input logic [32:0] x, input logic [32:0] k);
    if (!w) begin
      exp_q.push_back(x & k);
      msk_q.push_back(k);
    end
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // request stands until pready is seen high at a rising edge
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  // start an operation and poll until idle
  task run(input logic [31:0] ctrl);
    apb(1, `FWSR_OFF_CTRL, ctrl, 0, 0);
    repeat (300) begin
      apb(0, `FWSR_OFF_STATUS, 0, 0, 0);
      if (q[`FWSR_ST_BUSY] === 1'b0) break;
    end
    check("busy", {32'h0, q[`FWSR_ST_BUSY]}, 33'h0);
  endtask
  // read monitor compares with the oldest note
  always @(negedge pclk) if (psel && penable && pready && !pwrite) begin
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    if (m != 0) check("prdata", {pslverr, prdata} & m, e);
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, `FWSR_OFF_STATUS, 0, 33'h20, 33'h1FFFFFFFF);
    apb(0, 12'h020, 0, 33'h100000000, 33'h1FFFFFFFF);
    $display("register test done");
    rnd = lfsr(rnd);
    a = rnd & 32'hFFFFF;
    apb(1, `FWSR_OFF_ADDR, a, 0, 0);
    apb(1, `FWSR_OFF_WDATA, {16'h0, rnd[27:12]}, 0, 0);
    run(`FWSR_OP_WRITE);
    check("wr_addr", {13'h0, model.wa}, {1'b0, a});
    check("wr_data", {17'h0, model.wd}, {17'h0, rnd[27:12]});
    run(`FWSR_OP_READ);
    apb(0, `FWSR_OFF_RDATA, 0, {17'h0, a[15:0]}, 33'h1FFFFFFFF);
    $display("array test done");
    for (int i = 0; i < 2; i++) begin
      etimer <= i[0];
      n_busy <= 8'h04;
      go <= 1;
      @(posedge pclk);
      go <= 0;
      run(`FWSR_OP_READ);
      apb(0, `FWSR_OFF_RDATA, 0, {29'h0, i[0], 3'h0}, 33'hA8);
      apb(0, `FWSR_OFF_STATUS, 0, {28'h0, i[0], 4'h0}, 33'h30);
      run({27'h0, i[0], 2'h0, `FWSR_OP_POLL});
      apb(0, `FWSR_OFF_STATUS, 0, 33'h2A, 33'h2F);
    end
    $display("poll test done");
    fail <= 1;
    etimer <= 0;
    n_busy <= 8'h01;
    go <= 1;
    @(posedge pclk);
    go <= 0;
    run(`FWSR_OP_POLL);
    apb(0, `FWSR_OFF_STATUS, 0, 33'h6E, 33'h6F);
    check("reset_cmd", {17'h0, model.wd}, {17'h0, `FWSR_RESET_CMD});
    check("reset_addr", {13'h0, model.wa}, {1'b0, a});
    fail <= 0;
    $display("failure test done");
    results();
  end
endmodule // fwsr_host_tb_top
bind fwsr_host fwsr_host_props #(.AW(AW), .DW(DW)) u_props (.*);
